// *** hw/pmrv_consts.vh ***
// Purpose: Constants for the transceiver management register view.
// Assumes: Byte address = 4 * register index; bits [9:8] pick the view.
// Notes: View 0 is the switch port bank, views 1 and 2 the transceivers.
`ifndef PMRV_CONSTS_VH
`define PMRV_CONSTS_VH

// ************
// Address map
// ************
`define PMRV_VIEW_PORT 2'h0
`define PMRV_VIEW_XCVR1 2'h1
`define PMRV_VIEW_XCVR2 2'h2
`define PMRV_VIEW_IRQ 2'h3
`define PMRV_IDX_IDENT_HIGH 6'h02
`define PMRV_IDX_IDENT_LOW 6'h03
`define PMRV_IDX_ADVERTISE 6'h04
`define PMRV_IDX_LP_ABILITY 6'h05
`define PMRV_IDX_CABLE_DIAG 6'h1d
`define PMRV_IDX_SPECIAL 6'h1f
`define PMRV_IDX_IRQ_STATUS 6'h00
`define PMRV_IDX_IRQ_MASK 6'h01
// Port bank indices, port 1 base; port 2 adds PMRV_PORT_STRIDE
`define PMRV_PIDX_DIAG_CTRL 6'h1a
`define PMRV_PIDX_DIAG_COUNT 6'h1b
`define PMRV_PIDX_ADV 6'h1c
`define PMRV_PIDX_STATUS 6'h1e
`define PMRV_PIDX_SPECIAL 6'h1f
`define PMRV_PORT_STRIDE 6'h10

// ************
// Field positions
// ************
`define PMRV_ADV_PAUSE_BIT 10
`define PMRV_ADV_LO_BIT 5
`define PMRV_ADV_HI_BIT 8
`define PMRV_DIAG_START_BIT 15
`define PMRV_DIAG_RES_HI 14
`define PMRV_DIAG_RES_LO 13
`define PMRV_DIAG_SHORT_BIT 12
`define PMRV_DIAG_CNT_HI 8
`define PMRV_SPC_POL_BIT 5
`define PMRV_SPC_FLINK_BIT 3
`define PMRV_SPC_PSAVE_BIT 2
`define PMRV_SPC_RLOOP_BIT 1
`define PMRV_SPC_RES0_BIT 0
`define PMRV_PB_START_BIT 4
`define PMRV_PB_PAUSE_BIT 4

// ************
// Reset values
// ************
`define PMRV_ADV_PAUSE_RST 1'b1
`define PMRV_ADV_ABIL_RST 4'hf
`define PMRV_PSAVE_RST 1'b1
`define PMRV_SELECTOR 5'h01
`define PMRV_IRQ_W 4

`endif

// *** hw/pmrv_top.v ***
// Purpose: AHB-Lite register view of two transceivers' management words.
// Assumes: Transceiver core runs on hclk; its status inputs need no sync.
// Notes: Transceiver and switch port views share one set of flip-flops.
`timescale 1ns/10ps
`include "pmrv_consts.vh"

module pmrv_top #(
  parameter [15:0] IDENT_UPPER = 16'h5a5a, // Arbitrary value
  parameter [15:0] IDENT_LOWER = 16'ha5a5  // Arbitrary value
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  output wire irq,
  input wire [9:0] lp_ability,
  input wire [1:0] polarity_rev,
  input wire [1:0] diag_done,
  input wire [3:0] diag_result,
  input wire [1:0] diag_near_short,
  input wire [17:0] diag_count,
  output wire [1:0] adv_pause,
  output wire [7:0] adv_ability,
  output wire [1:0] diag_start,
  output wire [1:0] power_save_dis,
  output wire [1:0] remote_loopback,
  output wire [1:0] force_link
);

  // ************
  // Bus front end
  // ************
  reg [31:0] hrdata_reg;
  reg hreadyout_reg;
  reg hresp_reg;
  reg wr_pend_reg;
  reg [9:0] wr_addr_reg;
  reg [31:0] rd_word;
  wire addr_phase;
  wire rd_take;
  wire wr_take;
  wire [1:0] rd_view;
  wire [5:0] rd_idx;
  wire [1:0] wr_view;
  wire [5:0] wr_idx;

  assign addr_phase = hsel & hready & htrans[1];
  assign rd_take = addr_phase & ~hwrite;
  assign wr_take = addr_phase & hwrite;
  assign rd_view = haddr[9:8];
  assign rd_idx = haddr[7:2];
  assign wr_view = wr_addr_reg[9:8];
  assign wr_idx = wr_addr_reg[7:2];

  // Answer is always in the first data cycle; no wait states
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_reg <= 1'b0;
      hresp_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 10'h000;
      hrdata_reg <= 32'h00000000;
    end else begin
      hreadyout_reg <= 1'b1;
      // Always OKAY; kept in a flop so every output is registered
      hresp_reg <= 1'b0;
      wr_pend_reg <= wr_take;
      if (wr_take) begin
        wr_addr_reg <= haddr[9:0];
      end
      // Loaded at the address edge: a read whose address phase overlaps a write's data phase sees the old word
      if (rd_take) begin
        hrdata_reg <= rd_word;
      end
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;

  // Port bank index of a field for port p (0 or 1)
  function [5:0] pidx;
    input [5:0] base;
    input integer p;
    begin
      pidx = (p == 0) ? base : base + `PMRV_PORT_STRIDE;
    end
  endfunction

  // Match of a view and an index; shared by read and write decode
  function reg_hit;
    input [1:0] av;
    input [5:0] ai;
    input [1:0] view;
    input [5:0] idx;
    begin
      reg_hit = (av == view) & (ai == idx);
    end
  endfunction

  // ************
  // Per-port storage
  // ************
  reg [`PMRV_IRQ_W-1:0] irq_set;
  wire [31:0] xcvr_adv [0:1];
  wire [31:0] xcvr_lp [0:1];
  wire [31:0] xcvr_diag [0:1];
  wire [31:0] xcvr_spc [0:1];
  wire [7:0] pb_diag_ctrl [0:1];
  wire [7:0] pb_diag_cnt [0:1];
  wire [7:0] pb_adv [0:1];
  wire [7:0] pb_status [0:1];
  wire [7:0] pb_spc [0:1];
  wire [1:0] ev_done;
  wire [1:0] ev_pol;

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : port
      reg adv_pause_reg;
      reg [3:0] adv_abil_reg;
      reg run_reg;
      reg [1:0] result_reg;
      reg short_reg;
      reg [8:0] count_reg;
      reg flink_reg;
      reg psave_reg;
      reg rloop_reg;
      reg res0_reg;
      reg pol_prev_reg;
      wire [1:0] own_view;
      wire adv_wr;
      wire pb_adv_wr;
      wire spc_wr;
      wire diag_wr;
      wire pb_ctrl_wr;
      wire start_req;
      wire diag_cap;

      // ************
      // Write strobes
      // ************
      assign own_view = (p == 0) ? `PMRV_VIEW_XCVR1 : `PMRV_VIEW_XCVR2;
      // Either view writes the same flops, but only the transceiver view writes res0_reg
      assign adv_wr = wr_pend_reg & reg_hit(wr_view, wr_idx, own_view, `PMRV_IDX_ADVERTISE);
      assign pb_adv_wr = wr_pend_reg &
                         reg_hit(wr_view, wr_idx, `PMRV_VIEW_PORT, pidx(`PMRV_PIDX_ADV, p));
      assign spc_wr = wr_pend_reg & reg_hit(wr_view, wr_idx, own_view, `PMRV_IDX_SPECIAL);
      assign diag_wr = wr_pend_reg & reg_hit(wr_view, wr_idx, own_view, `PMRV_IDX_CABLE_DIAG);
      assign pb_ctrl_wr = wr_pend_reg &
                          reg_hit(wr_view, wr_idx, `PMRV_VIEW_PORT, pidx(`PMRV_PIDX_DIAG_CTRL, p));
      // Writing 0 to the start bit never aborts a running test
      assign start_req = (diag_wr & hwdata[`PMRV_DIAG_START_BIT]) |
                         (pb_ctrl_wr & hwdata[`PMRV_PB_START_BIT]);
      // A finish pulse without a running test is dropped
      assign diag_cap = diag_done[p] & run_reg;

      // ************
      // Control and diagnostic flops
      // ************
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          adv_pause_reg <= `PMRV_ADV_PAUSE_RST;
          adv_abil_reg <= `PMRV_ADV_ABIL_RST;
          run_reg <= 1'b0;
          result_reg <= 2'h0;
          short_reg <= 1'b0;
          count_reg <= 9'h000;
          flink_reg <= 1'b0;
          psave_reg <= `PMRV_PSAVE_RST;
          rloop_reg <= 1'b0;
          res0_reg <= 1'b0;
          pol_prev_reg <= 1'b0;
        end else begin
          pol_prev_reg <= polarity_rev[p];
          if (adv_wr) begin
            adv_pause_reg <= hwdata[`PMRV_ADV_PAUSE_BIT];
            adv_abil_reg <= hwdata[`PMRV_ADV_HI_BIT:`PMRV_ADV_LO_BIT];
          end else if (pb_adv_wr) begin
            adv_pause_reg <= hwdata[`PMRV_PB_PAUSE_BIT];
            adv_abil_reg <= hwdata[3:0];
          end
          if (spc_wr) begin
            flink_reg <= hwdata[`PMRV_SPC_FLINK_BIT];
            psave_reg <= hwdata[`PMRV_SPC_PSAVE_BIT];
            rloop_reg <= hwdata[`PMRV_SPC_RLOOP_BIT];
            res0_reg <= hwdata[`PMRV_SPC_RES0_BIT];
          end else if (pb_ctrl_wr) begin
            flink_reg <= hwdata[3];
            psave_reg <= hwdata[2];
            rloop_reg <= hwdata[1];
          end
          // Finish ends the run; a start while running is ignored
          if (diag_cap) begin
            run_reg <= 1'b0;
            result_reg <= diag_result[2*p+1:2*p];
            short_reg <= diag_near_short[p];
            count_reg <= diag_count[9*p+8:9*p];
          end else if (start_req) begin
            run_reg <= 1'b1;
          end
        end
      end

      assign ev_done[p] = diag_cap;
      assign ev_pol[p] = polarity_rev[p] ^ pol_prev_reg;

      assign adv_pause[p] = adv_pause_reg;
      assign adv_ability[4*p+3:4*p] = adv_abil_reg;
      assign diag_start[p] = run_reg;
      assign power_save_dis[p] = psave_reg;
      assign remote_loopback[p] = rloop_reg;
      assign force_link[p] = flink_reg;

      // Transceiver view words; unlisted bits stay 0
      assign xcvr_adv[p] = {21'h0, adv_pause_reg, 1'b0, adv_abil_reg, `PMRV_SELECTOR};
      assign xcvr_lp[p] = {21'h0, lp_ability[5*p+4], 1'b0, lp_ability[5*p+3:5*p], 5'h00};
      assign xcvr_diag[p] = {16'h0000, run_reg, result_reg, short_reg, 3'h0, count_reg};
      assign xcvr_spc[p] = {26'h0, polarity_rev[p], 1'b0, flink_reg, psave_reg, rloop_reg,
                            res0_reg};
      // Switch port view bytes
      assign pb_diag_ctrl[p] = {short_reg, result_reg, run_reg, flink_reg, psave_reg, rloop_reg,
                                count_reg[`PMRV_DIAG_CNT_HI]};
      assign pb_diag_cnt[p] = count_reg[7:0];
      assign pb_adv[p] = {3'h0, adv_pause_reg, adv_abil_reg};
      assign pb_status[p] = {3'h0, lp_ability[5*p+4:5*p]};
      assign pb_spc[p] = {2'h0, polarity_rev[p], 5'h00};
    end
  endgenerate

  // ************
  // Interrupts
  // ************
  reg [`PMRV_IRQ_W-1:0] irq_stat_reg;
  reg [`PMRV_IRQ_W-1:0] irq_stat_next;
  reg [`PMRV_IRQ_W-1:0] irq_mask_reg;
  reg [`PMRV_IRQ_W-1:0] irq_mask_next;
  reg irq_reg;
  wire stat_rd;
  wire mask_wr;

  assign stat_rd = rd_take & reg_hit(rd_view, rd_idx, `PMRV_VIEW_IRQ, `PMRV_IDX_IRQ_STATUS);
  assign mask_wr = wr_pend_reg & reg_hit(wr_view, wr_idx, `PMRV_VIEW_IRQ, `PMRV_IDX_IRQ_MASK);

  always @* begin
    irq_set = {ev_pol, ev_done};
    // A new event beats the read that clears
    irq_stat_next = (irq_stat_reg & {`PMRV_IRQ_W{~stat_rd}}) | irq_set;
    // New mask acts on irq at the edge that stores it, so no stale cycle
    irq_mask_next = irq_mask_reg;
    if (mask_wr) begin
      irq_mask_next = hwdata[`PMRV_IRQ_W-1:0];
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_reg <= {`PMRV_IRQ_W{1'b0}};
      irq_mask_reg <= {`PMRV_IRQ_W{1'b0}};
      irq_reg <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg <= |(irq_stat_next & irq_mask_next);
    end
  end

  assign irq = irq_reg;

  // ************
  // Read decode
  // ************
  integer q;
  always @* begin
    rd_word = 32'h00000000;
    case (rd_view)
      `PMRV_VIEW_XCVR1, `PMRV_VIEW_XCVR2: begin
        q = (rd_view == `PMRV_VIEW_XCVR1) ? 0 : 1;
        case (rd_idx)
          `PMRV_IDX_IDENT_HIGH: rd_word = {16'h0000, IDENT_UPPER};
          `PMRV_IDX_IDENT_LOW: rd_word = {16'h0000, IDENT_LOWER};
          `PMRV_IDX_ADVERTISE: rd_word = xcvr_adv[q];
          `PMRV_IDX_LP_ABILITY: rd_word = xcvr_lp[q];
          `PMRV_IDX_CABLE_DIAG: rd_word = xcvr_diag[q];
          `PMRV_IDX_SPECIAL: rd_word = xcvr_spc[q];
          default: rd_word = 32'h00000000;
        endcase
      end
      `PMRV_VIEW_PORT: begin
        q = (rd_idx >= pidx(`PMRV_PIDX_DIAG_CTRL, 1)) ? 1 : 0;
        if (rd_idx == pidx(`PMRV_PIDX_DIAG_CTRL, q)) begin
          rd_word = {24'h000000, pb_diag_ctrl[q]};
        end else if (rd_idx == pidx(`PMRV_PIDX_DIAG_COUNT, q)) begin
          rd_word = {24'h000000, pb_diag_cnt[q]};
        end else if (rd_idx == pidx(`PMRV_PIDX_ADV, q)) begin
          rd_word = {24'h000000, pb_adv[q]};
        end else if (rd_idx == pidx(`PMRV_PIDX_STATUS, q)) begin
          rd_word = {24'h000000, pb_status[q]};
        end else if (rd_idx == pidx(`PMRV_PIDX_SPECIAL, q)) begin
          rd_word = {24'h000000, pb_spc[q]};
        end
      end
      `PMRV_VIEW_IRQ: begin
        q = 0;
        if (rd_idx == `PMRV_IDX_IRQ_STATUS) begin
          rd_word = {28'h0000000, irq_stat_reg};
        end else if (rd_idx == `PMRV_IDX_IRQ_MASK) begin
          rd_word = {28'h0000000, irq_mask_reg};
        end
      end
      default: q = 0;
    endcase
  end

endmodule

// *** tb/pmrv_properties.sv ***
// Purpose: Control-output properties of pmrv_top.
// Assumes: Single master, whole-word writes.
// Notes: Helper flops keep the last data-phase word and the previous cycle's diag_done.
`timescale 1ns/10ps
module pmrv_properties (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hwdata,
  input wire [1:0] diag_done,
  input wire [1:0] adv_pause,
  input wire [7:0] adv_ability,
  input wire [1:0] diag_start,
  input wire [1:0] power_save_dis,
  input wire [1:0] remote_loopback,
  input wire [1:0] force_link
);
  reg [31:0] wd_q;
  reg [1:0] dn_q;
  always @(posedge hclk) begin
    wd_q <= hwdata;
    dn_q <= diag_done;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ************
  // Write taken, then its data phase
  // ************
  sequence s_wr(logic [9:0] a);
    hsel && hready && htrans[1] && hwrite && haddr[9:0] == a ##1 1'b1;
  endsequence
  start_run_a: assert property (
    s_wr(10'h174) ##0 (hwdata[15] && !diag_start[0]) |=> diag_start[0])
    else $error("cable test did not start");
  test_clear_a: assert property (
    diag_start[0] && diag_done[0] |=> !diag_start[0])
    else $error("start bit did not clear");
  start_cause_a: assert property (
    $rose(diag_start[0]) |-> $past(hwrite, 2) && (wd_q[15] || wd_q[4]))
    else $error("test started without a write");
  clear_cause_a: assert property (
    $fell(diag_start[0]) |-> dn_q[0])
    else $error("start bit cleared early");
  adv_write_a: assert property (
    s_wr(10'h110) |=> adv_pause[0] == wd_q[10] && adv_ability[3:0] == wd_q[8:5])
    else $error("advertise controls wrong");
  adv_alias_a: assert property (
    s_wr(10'h0b0) |=> adv_pause[1] == wd_q[4] && adv_ability[7:4] == wd_q[3:0])
    else $error("port view advertise wrong");
  special_write_a: assert property (
    s_wr(10'h17c) |=> power_save_dis[0] == wd_q[2] && remote_loopback[0] == wd_q[1])
    else $error("special controls wrong");
  port_ctl_a: assert property (
    s_wr(10'h068) |=> force_link[0] == wd_q[3] && power_save_dis[0] == wd_q[2])
    else $error("port view control wrong");
endmodule

// *** tb/pmrv_top_bench.sv ***
// Purpose: Self-checking bench for pmrv_top.
// Assumes: hready loops back from hreadyout.
// Notes: One task per scenario.
`timescale 1ns/10ps
module pmrv_top_bench;
  reg hclk, hresetn, hsel, hwrite;
  reg [31:0] haddr, hwdata, rd;
  reg [1:0] htrans, polarity_rev;
  reg [9:0] lp_ability;
  reg [11:0] diag_cfg;
  wire [31:0] hrdata;
  wire hreadyout, hresp, irq;
  wire [1:0] diag_done, diag_near_short, adv_pause, diag_start, power_save_dis, remote_loopback, force_link;
  wire [3:0] diag_result;
  wire [17:0] diag_count;
  wire [7:0] adv_ability;
  integer num_errors, tests_run;
  pmrv_top #(.IDENT_UPPER(16'h1234), .IDENT_LOWER(16'h0bcd)) pmrv_top_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout),
    .hwdata, .hrdata, .hreadyout, .hresp, .irq, .lp_ability, .polarity_rev, .diag_done,
    .diag_result, .diag_near_short, .diag_count, .adv_pause, .adv_ability, .diag_start,
    .power_save_dis, .remote_loopback, .force_link);
  pmrv_xcvr_model pmrv_xcvr_model_inst (
    .hclk, .diag_start, .diag_cfg, .diag_done, .diag_result, .diag_near_short, .diag_count);
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus(input [31:0] a, input w, input [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
    end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task rdc(input [31:0] a, input [31:0] exp);
    begin
      bus(a, 1'b0, 32'h0);
      chk(rd, exp);
    end
  endtask
  task t_reset;
    begin
      rdc(32'h108, 32'h1234);
      rdc(32'h20c, 32'h0bcd);
      wr(32'h108, 32'hffff);
      rdc(32'h108, 32'h1234);
      rdc(32'h110, 32'h05e1);
      rdc(32'h214, 32'h0);
      rdc(32'h174, 32'h0);
      rdc(32'h17c, 32'h4);
      rdc(32'h140, 32'h0);
      chk({31'h0, hresp}, 32'h0);
    end
  endtask
  task t_adv;
    begin
      wr(32'h110, 32'hffff);
      rdc(32'h110, 32'h05e1);
      wr(32'h110, 32'h0);
      rdc(32'h110, 32'h1);
      chk({27'h0, adv_pause[0], adv_ability[3:0]}, 32'h0);
      rdc(32'h070, 32'h0);
      wr(32'h0b0, 32'h15);
      rdc(32'h210, 32'h04a1);
      chk({27'h0, adv_pause[1], adv_ability[7:4]}, 32'h15);
      lp_ability <= {5'h0b, 5'h15};
      wr(32'h114, 32'hffff);
      rdc(32'h114, 32'h04a0);
      rdc(32'h214, 32'h0160);
    end
  endtask
  task t_diag;
    integer c, n;
    begin
      wr(32'h304, 32'h1);
      for (c = 0; c < 4; c = c + 1) begin
        diag_cfg <= {c[1:0], c[0], 9'h0a5 + c[8:0]};
        wr(32'h174, 32'h8000);
        n = 0;
        rd = 32'h8000;
        while (rd[15] === 1'b1 && n < 50) begin
          bus(32'h174, 1'b0, 32'h0);
          n = n + 1;
        end
        chk(rd, {16'h0, 1'b0, c[1:0], c[0], 3'h0, 9'h0a5 + c[8:0]});
        chk({31'h0, irq}, 32'h1);
        rdc(32'h300, 32'h1);
        chk({31'h0, irq}, 32'h0);
      end
    end
  endtask
  task t_special;
    begin
      wr(32'h304, 32'h0);
      polarity_rev <= 2'h1;
      wr(32'h17c, 32'h2);
      rdc(32'h17c, 32'h22);
      chk({30'h0, power_save_dis[0], remote_loopback[0]}, 32'h1);
      chk({31'h0, irq}, 32'h0);
      rdc(32'h300, 32'h4);
      wr(32'h068, 32'h0c);
      rdc(32'h17c, 32'h2c);
      rdc(32'h07c, 32'h20);
    end
  endtask
  task end_of_test;
    begin
      $display("Checks %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans} = 0;
    {polarity_rev, lp_ability, diag_cfg} = 0;
    num_errors = 0;
    tests_run = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_reset;
    t_adv;
    t_diag;
    t_special;
    end_of_test;
  end
  // Whole run needs about 150 cycles
  initial begin
    #400000;
    num_errors = num_errors + 1;
    end_of_test;
  end
endmodule
bind pmrv_top pmrv_properties pmrv_properties_inst (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .diag_done, .adv_pause,
  .adv_ability, .diag_start, .power_save_dis, .remote_loopback, .force_link);

// *** tb/pmrv_xcvr_model.sv ***
// Purpose: Transceiver core answering cable tests.
// Assumes: Same clock as the register view.
// Notes: Result lines carry junk outside the done pulse.
`timescale 1ns/10ps
module pmrv_xcvr_model #(
  parameter DELAY = 5
) (
  input wire hclk,
  input wire [1:0] diag_start,
  input wire [11:0] diag_cfg,
  output reg [1:0] diag_done,
  output wire [3:0] diag_result,
  output wire [1:0] diag_near_short,
  output wire [17:0] diag_count
);
  reg [3:0] wait_reg [0:1];
  integer i;
  initial diag_done = 2'h0;
  always @(posedge hclk) begin
    for (i = 0; i < 2; i = i + 1) begin
      diag_done[i] <= 1'b0;
      if (!diag_start[i] || diag_done[i])
        wait_reg[i] <= 4'h0;
      else if (wait_reg[i] == DELAY)
        diag_done[i] <= 1'b1;
      else
        wait_reg[i] <= wait_reg[i] + 4'h1;
    end
  end
  // Inverted outside done so a stale capture shows
  assign diag_result = {2{diag_cfg[11:10]}} ^ ~{{2{diag_done[1]}}, {2{diag_done[0]}}};
  assign diag_near_short = {2{diag_cfg[9]}} ^ ~diag_done;
  assign diag_count = {2{diag_cfg[8:0]}} ^ ~{{9{diag_done[1]}}, {9{diag_done[0]}}};
endmodule
